/* rtl/ssc_sleep_config.sv */
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/100ps
// How it works
// - Sleep source: type field or external inputs
// - Main supply off in suspend unless bit set
// - Hibernate joins suspend or soft-off group
// - Lock makes sleep config read-only until reset/unlock
// - Hardware reset clears ACPI configuration register
// - Alarm gate zero holds alarm status/enable
// - Sleep gate zero holds sleep button bits
module ssc_sleep_config
   import ssc_pkg::*;
#(
   parameter int         PULSE_CYCLES   = ssc_pkg::SSC_PULSE_CYCLES,
   parameter logic [2:0] SUSPEND_CODE   = 3'h1,
   parameter logic [2:0] HIBERNATE_CODE = 3'h2,
   parameter logic [2:0] SOFT_OFF_CODE  = 3'h3
)
(
   // Clock and reset
   input  wire logic                             aclk,
   input  wire logic                             aresetn,
   // AXI4-Lite write address
   input  wire logic [ssc_pkg::SSC_AXI_AW-1:0]   s_axi_awaddr,
   input  wire logic [2:0]                       s_axi_awprot,
   input  wire logic                             s_axi_awvalid,
   output logic                                  s_axi_awready,
   // AXI4-Lite write data
   input  wire logic [ssc_pkg::SSC_AXI_DW-1:0]   s_axi_wdata,
   input  wire logic [3:0]                       s_axi_wstrb,
   input  wire logic                             s_axi_wvalid,
   output logic                                  s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]                            s_axi_bresp,
   output logic                                  s_axi_bvalid,
   input  wire logic                             s_axi_bready,
   // AXI4-Lite read address
   input  wire logic [ssc_pkg::SSC_AXI_AW-1:0]   s_axi_araddr,
   input  wire logic [2:0]                       s_axi_arprot,
   input  wire logic                             s_axi_arvalid,
   output logic                                  s_axi_arready,
   // AXI4-Lite read data
   output logic [ssc_pkg::SSC_AXI_DW-1:0]        s_axi_rdata,
   output logic [1:0]                            s_axi_rresp,
   output logic                                  s_axi_rvalid,
   input  wire logic                             s_axi_rready,
   // External sleep state inputs
   input  wire logic                             external_suspend_ram_input,
   input  wire logic                             external_soft_off_input,
   // Event sources
   input  wire logic                             alarm_event,
   input  wire logic                             sleep_button_event,
   input  wire logic                             power_button_event,
   input  wire logic                             wake_event,
   input  wire logic                             power_button_input,
   input  wire logic                             crowbar_condition,
   input  wire logic                             unlock_request,
   // Power control outputs
   output logic                                  power_button_output,
   output logic                                  main_supply_on,
   output logic                                  suspend_ram_group,
   output logic                                  soft_off_group
);
   import ssc_pkg::*;

   function automatic logic idx_mapped(input logic [SSC_AXI_AW-1:0] addr);
      logic [7:0] idx;
      idx = addr[SSC_AXI_AW-1:2];
      idx_mapped = (idx >= SSC_IDX_SLEEP) && (idx <= SSC_IDX_STATE);
   endfunction : idx_mapped

   localparam logic [7:0] PULSE_LOAD = 8'(PULSE_CYCLES);

   // Bus state
   logic                     aw_got_r,  aw_got_nxt;
   logic [SSC_AXI_AW-1:0]    aw_addr_r, aw_addr_nxt;
   logic                     w_got_r,   w_got_nxt;
   logic [7:0]               w_byte_r,  w_byte_nxt;
   logic                     w_lane_r,  w_lane_nxt;
   logic                     bvalid_r,  bvalid_nxt;
   logic [1:0]               bresp_r,   bresp_nxt;
   logic                     rvalid_r,  rvalid_nxt;
   logic [1:0]               rresp_r,   rresp_nxt;
   logic [SSC_AXI_DW-1:0]    rdata_r,   rdata_nxt;

   // Register state
   logic [7:0]               sleep_cfg_r, sleep_cfg_nxt;
   logic [7:0]               acpi_event_config_r,  acpi_event_config_nxt;
   logic [2:0]               sts_r,       sts_nxt;
   logic [2:0]               en_r,        en_nxt;
   logic [2:0]               type_r,      type_nxt;

   // Power state
   logic                     suspend_r,   suspend_nxt;
   logic                     soft_off_r,  soft_off_nxt;
   logic                     supply_r,    supply_nxt;
   logic                     btn_prev_r,  btn_prev_nxt;
   logic [7:0]               pulse_cnt_r, pulse_cnt_nxt;
   logic                     pulse_r,     pulse_nxt;

   // Combinational helpers
   logic                     aw_hs, w_hs, ar_hs;
   logic                     have_aw, have_w, do_write;
   logic [SSC_AXI_AW-1:0]    wr_addr;
   logic [7:0]               wr_idx, wr_byte;
   logic                     wr_lane;
   logic [2:0]               gate;
   logic [2:0]               evt_in;
   logic                     wake_any;
   logic                     trigger;
   logic [7:0]               rd_byte;

   assign s_axi_awready = !aw_got_r && !bvalid_r;
   assign s_axi_wready  = !w_got_r && !bvalid_r;
   assign s_axi_arready = !rvalid_r;
   assign s_axi_bvalid  = bvalid_r;
   assign s_axi_bresp   = bresp_r;
   assign s_axi_rvalid  = rvalid_r;
   assign s_axi_rresp   = rresp_r;
   assign s_axi_rdata   = rdata_r;

   assign power_button_output = pulse_r;
   assign main_supply_on      = supply_r;
   assign suspend_ram_group   = suspend_r;
   assign soft_off_group      = soft_off_r;

   // Bus handshake and write path
   always_comb
   begin
      aw_hs      = s_axi_awvalid && s_axi_awready;
      w_hs       = s_axi_wvalid && s_axi_wready;
      ar_hs      = s_axi_arvalid && s_axi_arready;
      have_aw    = aw_got_r || aw_hs;
      have_w     = w_got_r || w_hs;
      do_write   = have_aw && have_w;
      wr_addr    = aw_got_r ? aw_addr_r : s_axi_awaddr;
      wr_byte    = w_got_r ? w_byte_r : s_axi_wdata[7:0];
      wr_lane    = w_got_r ? w_lane_r : s_axi_wstrb[0];
      wr_idx     = wr_addr[SSC_AXI_AW-1:2];
      aw_addr_nxt = aw_hs ? s_axi_awaddr : aw_addr_r;
      w_byte_nxt  = w_hs ? s_axi_wdata[7:0] : w_byte_r;
      w_lane_nxt  = w_hs ? s_axi_wstrb[0] : w_lane_r;
      aw_got_nxt = have_aw && !do_write;
      w_got_nxt  = have_w && !do_write;
      bvalid_nxt = bvalid_r;
      bresp_nxt  = bresp_r;
      if (bvalid_r && s_axi_bready)
      begin
         bvalid_nxt = 1'b0;
      end
      if (do_write)
      begin
         bvalid_nxt = 1'b1;
         bresp_nxt  = idx_mapped(wr_addr) ? SSC_RESP_OKAY : SSC_RESP_SLVERR;
      end
   end

   // Configuration and event registers
   always_comb
   begin
      sleep_cfg_nxt = sleep_cfg_r;
      acpi_event_config_nxt  = acpi_event_config_r;
      en_nxt        = en_r;
      type_nxt      = type_r;
      sts_nxt       = sts_r;
      gate          = {acpi_event_config_r[SSC_ALARM_GATE_BIT], acpi_event_config_r[SSC_SLEEP_GATE_BIT],
                       acpi_event_config_r[SSC_POWER_GATE_BIT]};
      evt_in        = {alarm_event, sleep_button_event, power_button_event};
      if (do_write && wr_lane)
      begin
         case (wr_idx)
            SSC_IDX_SLEEP:
            begin
               // Lock covers itself, so a locked register stays as it is
               if (!sleep_cfg_r[SSC_LOCK_BIT])
               begin
                  sleep_cfg_nxt = (wr_byte & SSC_SLEEP_MASK)
                                | {wr_byte[SSC_LOCK_BIT], 7'h00};
               end
            end
            SSC_IDX_ACPI:    acpi_event_config_nxt = wr_byte & SSC_ACPI_MASK;
            SSC_IDX_PM1_STS: sts_nxt      = sts_r & ~wr_byte[2:0];
            SSC_IDX_PM1_EN:  en_nxt       = wr_byte[2:0] & SSC_EVT_MASK;
            SSC_IDX_PM1_CNT: type_nxt     = wr_byte[SSC_TYPE_LSB +: 3];
            default:         sleep_cfg_nxt = sleep_cfg_r;
         endcase
      end
      // Explicit unlock releases the lock
      if (unlock_request)
      begin
         sleep_cfg_nxt[SSC_LOCK_BIT] = 1'b0;
      end
      // Set wins over a same-cycle clear
      sts_nxt = sts_nxt | evt_in;
      // Closed gates pin status and enable at zero
      sts_nxt = sts_nxt & gate;
      en_nxt  = en_nxt & gate;
   end

   // Sleep group and supply decode
   always_comb
   begin
      if (!sleep_cfg_r[SSC_SRC_SEL_BIT])
      begin
         suspend_nxt  = (type_r == SUSPEND_CODE)
                      || ((type_r == HIBERNATE_CODE) && sleep_cfg_r[SSC_HIB_SEL_BIT]);
         soft_off_nxt = (type_r == SOFT_OFF_CODE)
                      || ((type_r == HIBERNATE_CODE) && !sleep_cfg_r[SSC_HIB_SEL_BIT]);
      end
      else
      begin
         // External controller gives no separate hibernate indication
         suspend_nxt  = external_suspend_ram_input;
         soft_off_nxt = external_soft_off_input;
      end
      supply_nxt = !soft_off_nxt
                 && !(suspend_nxt && !sleep_cfg_r[SSC_SUPPLY_BIT]);
   end

   // Power button output pulse
   always_comb
   begin
      btn_prev_nxt  = power_button_input;
      wake_any      = wake_event || (|(evt_in & gate & en_r));
      trigger       = (power_button_input && !btn_prev_r) || crowbar_condition
                    || (!acpi_event_config_r[SSC_PULSE_MODE_BIT] && wake_any);
      pulse_cnt_nxt = pulse_cnt_r;
      if (trigger)
      begin
         pulse_cnt_nxt = PULSE_LOAD;
      end
      else if (pulse_cnt_r != SSC_CNT_ZERO)
      begin
         pulse_cnt_nxt = pulse_cnt_r - 8'h01;
      end
      pulse_nxt = (pulse_cnt_nxt != SSC_CNT_ZERO);
   end

   // Read path
   always_comb
   begin
      case (s_axi_araddr[SSC_AXI_AW-1:2])
         SSC_IDX_SLEEP:   rd_byte = sleep_cfg_r;
         SSC_IDX_ACPI:    rd_byte = acpi_event_config_r;
         SSC_IDX_PM1_STS: rd_byte = {5'h00, sts_r};
         SSC_IDX_PM1_EN:  rd_byte = {5'h00, en_r};
         SSC_IDX_PM1_CNT: rd_byte = {3'h0, type_r, 2'h0};
         SSC_IDX_STATE:   rd_byte = {5'h00, supply_r, soft_off_r, suspend_r};
         default:         rd_byte = 8'h00;
      endcase
      rvalid_nxt = rvalid_r;
      rresp_nxt  = rresp_r;
      rdata_nxt  = rdata_r;
      if (rvalid_r && s_axi_rready)
      begin
         rvalid_nxt = 1'b0;
      end
      if (ar_hs)
      begin
         rvalid_nxt = 1'b1;
         rdata_nxt  = {24'h000000, rd_byte};
         rresp_nxt  = idx_mapped(s_axi_araddr) ? SSC_RESP_OKAY : SSC_RESP_SLVERR;
      end
   end

   // Bus registers
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_got_r  <= 1'b0;
         aw_addr_r <= '0;
         w_got_r   <= 1'b0;
         w_byte_r  <= 8'h00;
         w_lane_r  <= 1'b0;
         bvalid_r  <= 1'b0;
         bresp_r   <= SSC_RESP_OKAY;
         rvalid_r  <= 1'b0;
         rresp_r   <= SSC_RESP_OKAY;
         rdata_r   <= 32'h00000000;
      end
      else
      begin
         aw_got_r  <= aw_got_nxt;
         aw_addr_r <= aw_addr_nxt;
         w_got_r   <= w_got_nxt;
         w_byte_r  <= w_byte_nxt;
         w_lane_r  <= w_lane_nxt;
         bvalid_r  <= bvalid_nxt;
         bresp_r   <= bresp_nxt;
         rvalid_r  <= rvalid_nxt;
         rresp_r   <= rresp_nxt;
         rdata_r   <= rdata_nxt;
      end
   end

   // Block registers
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         sleep_cfg_r <= SSC_SLEEP_RST;
         acpi_event_config_r  <= SSC_ACPI_RST;
         sts_r       <= SSC_EVT_RST;
         en_r        <= SSC_EVT_RST;
         type_r      <= SSC_TYPE_RST;
         suspend_r   <= 1'b0;
         soft_off_r  <= 1'b0;
         supply_r    <= 1'b1;
         btn_prev_r  <= 1'b0;
         pulse_cnt_r <= SSC_CNT_ZERO;
         pulse_r     <= 1'b0;
      end
      else
      begin
         sleep_cfg_r <= sleep_cfg_nxt;
         acpi_event_config_r  <= acpi_event_config_nxt;
         sts_r       <= sts_nxt;
         en_r        <= en_nxt;
         type_r      <= type_nxt;
         suspend_r   <= suspend_nxt;
         soft_off_r  <= soft_off_nxt;
         supply_r    <= supply_nxt;
         btn_prev_r  <= btn_prev_nxt;
         pulse_cnt_r <= pulse_cnt_nxt;
         pulse_r     <= pulse_nxt;
      end
   end

endmodule : ssc_sleep_config

/* common/ssc_pkg.sv */
package ssc_pkg;

   // Bus geometry
   localparam int          SSC_AXI_AW       = 10;
   localparam int          SSC_AXI_DW       = 32;

   // Register indices; byte address is four times the index
   localparam logic [7:0]  SSC_IDX_SLEEP    = 8'h16;
   localparam logic [7:0]  SSC_IDX_ACPI     = 8'h17;
   localparam logic [7:0]  SSC_IDX_PM1_STS  = 8'h18;
   localparam logic [7:0]  SSC_IDX_PM1_EN   = 8'h19;
   localparam logic [7:0]  SSC_IDX_PM1_CNT  = 8'h1A;
   localparam logic [7:0]  SSC_IDX_STATE    = 8'h1B;

   // sleep_state_config fields
   localparam int          SSC_LOCK_BIT     = 7;
   localparam int          SSC_SRC_SEL_BIT  = 2;
   localparam int          SSC_SUPPLY_BIT   = 1;
   localparam int          SSC_HIB_SEL_BIT  = 0;
   localparam logic [7:0]  SSC_SLEEP_MASK   = 8'h07;
   localparam logic [7:0]  SSC_SLEEP_RST    = 8'h00;

   // acpi_event_config fields
   localparam int          SSC_PULSE_MODE_BIT = 7;
   localparam int          SSC_ALARM_GATE_BIT = 2;
   localparam int          SSC_SLEEP_GATE_BIT = 1;
   localparam int          SSC_POWER_GATE_BIT = 0;
   localparam logic [7:0]  SSC_ACPI_MASK    = 8'h87;
   localparam logic [7:0]  SSC_ACPI_RST     = 8'h00;

   // PM1 status and enable high fields: power, sleep, alarm
   localparam logic [2:0]  SSC_EVT_MASK     = 3'h7;
   localparam logic [2:0]  SSC_EVT_RST      = 3'h0;

   // PM1 control high sleep type field
   localparam int          SSC_TYPE_LSB     = 2;
   localparam logic [2:0]  SSC_TYPE_RST     = 3'h0;

   // Bus responses
   localparam logic [1:0]  SSC_RESP_OKAY    = 2'h0;
   localparam logic [1:0]  SSC_RESP_SLVERR  = 2'h2;

   // Power button output pulse length, cycles
   localparam int          SSC_PULSE_CYCLES = 4;
   localparam logic [7:0]  SSC_CNT_ZERO     = 8'h00;

endpackage : ssc_pkg

/* bench/ssc_sleep_config_monitor.sv */
`timescale 1ns/100ps
module ssc_sleep_config_monitor
   import ssc_pkg::*;
(
   // Clock and reset
   input wire logic                  aclk,
   input wire logic                  aresetn,
   // Register bus
   input wire logic                  s_axi_awvalid,
   input wire logic                  s_axi_awready,
   input wire logic                  s_axi_wvalid,
   input wire logic                  s_axi_wready,
   input wire logic                  s_axi_bvalid,
   input wire logic                  s_axi_bready,
   input wire logic                  s_axi_arvalid,
   input wire logic                  s_axi_arready,
   input wire logic [ssc_pkg::SSC_AXI_DW-1:0] s_axi_rdata,
   input wire logic                  s_axi_rvalid,
   input wire logic                  s_axi_rready,
   // Power side
   input wire logic                  power_button_input,
   input wire logic                  crowbar_condition,
   input wire logic                  power_button_output,
   input wire logic                  main_supply_on,
   input wire logic                  suspend_ram_group,
   input wire logic                  soft_off_group
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   write_answer_a : assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready |=> s_axi_bvalid) else $error("write response late");
   read_answer_a : assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data late");
   bvalid_hold_a : assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped");
   rdata_upper_a : assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
      else $error("read data upper bits set");
   supply_off_a : assert property (soft_off_group |-> !main_supply_on)
      else $error("supply on in soft-off");
   group_excl_a : assert property (!(suspend_ram_group && soft_off_group))
      else $error("two groups at once");
   button_pulse_a : assert property ($rose(power_button_input) |=> power_button_output [*4])
      else $error("button pulse too short");
   crowbar_pulse_a : assert property (crowbar_condition |=> power_button_output)
      else $error("no pulse on crowbar");
endmodule : ssc_sleep_config_monitor

bind ssc_sleep_config ssc_sleep_config_monitor i_mon
(
   .aclk                (aclk),
   .aresetn             (aresetn),
   .s_axi_awvalid       (s_axi_awvalid),
   .s_axi_awready       (s_axi_awready),
   .s_axi_wvalid        (s_axi_wvalid),
   .s_axi_wready        (s_axi_wready),
   .s_axi_bvalid        (s_axi_bvalid),
   .s_axi_bready        (s_axi_bready),
   .s_axi_arvalid       (s_axi_arvalid),
   .s_axi_arready       (s_axi_arready),
   .s_axi_rdata         (s_axi_rdata),
   .s_axi_rvalid        (s_axi_rvalid),
   .s_axi_rready        (s_axi_rready),
   .power_button_input  (power_button_input),
   .crowbar_condition   (crowbar_condition),
   .power_button_output (power_button_output),
   .main_supply_on      (main_supply_on),
   .suspend_ram_group   (suspend_ram_group),
   .soft_off_group      (soft_off_group)
);

/* bench/ssc_acpi_model.sv */
`timescale 1ns/100ps
module ssc_acpi_model
(
   // Clock and reset
   input  wire logic       aclk,
   input  wire logic       aresetn,
   // Request: 0 working, 1 suspend, 2 soft-off; slow adds a stage
   input  wire logic [1:0] state_req,
   input  wire logic       slow,
   // Sleep state lines
   output logic            suspend_out,
   output logic            soft_off_out
);
   logic [1:0] stage_r, out_r, out_nxt;
   always_comb
      out_nxt = slow ? stage_r : state_req;
   always_ff @(posedge aclk)
   begin
      stage_r <= aresetn ? state_req : 2'h0;
      out_r   <= aresetn ? out_nxt : 2'h0;
   end
   // One state at a time, so the two lines are never high together
   assign suspend_out  = (out_r == 2'h1);
   assign soft_off_out = (out_r == 2'h2);
endmodule : ssc_acpi_model

/* bench/test_sleep_state_acpi_event_config.sv */
`timescale 1ns/100ps
module test_sleep_state_acpi_event_config;
   import ssc_pkg::*;
   localparam logic [9:0] A_SLP = {SSC_IDX_SLEEP, 2'h0};
   localparam logic [9:0] A_ACPI = {SSC_IDX_ACPI, 2'h0};
   localparam logic [9:0] A_STS = {SSC_IDX_PM1_STS, 2'h0};
   localparam logic [9:0] A_EN = {SSC_IDX_PM1_EN, 2'h0};
   localparam logic [9:0] A_CNT = {SSC_IDX_PM1_CNT, 2'h0};
   localparam logic [9:0] A_ST = {SSC_IDX_STATE, 2'h0};
   logic        aclk = 1'h0, aresetn = 1'h0;
   logic [9:0]  s_axi_awaddr = 10'h0, s_axi_araddr = 10'h0;
   logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0]  s_axi_wstrb = 4'h1;
   logic [1:0]  s_axi_bresp, s_axi_rresp, ext_req = 2'h0;
   logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, unlock_request = 1'h0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic        external_suspend_ram_input, external_soft_off_input, ext_slow = 1'h0;
   logic        power_button_output, main_supply_on, suspend_ram_group, soft_off_group;
   logic [2:0]  evt = 3'h0, trig = 3'h0;
   wire logic   alarm_event = evt[2], sleep_button_event = evt[1], power_button_event = evt[0];
   wire logic   wake_event = trig[0], power_button_input = trig[1], crowbar_condition = trig[2];
   int          n_fail = 0, n_checks = 0;
   // Columns: sleep config, sleep type, external request, expected state
   logic [7:0]  t_cfg [9] = '{8'h00, 8'h02, 8'h00, 8'h01, 8'h00, 8'h04, 8'h04, 8'h06, 8'h04};
   logic [2:0]  t_typ [9] = '{3'h1, 3'h1, 3'h2, 3'h2, 3'h3, 3'h3, 3'h0, 3'h0, 3'h1};
   logic [1:0]  t_ext [9] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h1, 2'h2};
   logic [7:0]  t_st [9] = '{8'h01, 8'h05, 8'h02, 8'h01, 8'h02, 8'h04, 8'h01, 8'h05, 8'h02};

   always #2.5 aclk = ~aclk;
   ssc_sleep_config i_dut
   (
      .aclk                       (aclk),
      .aresetn                    (aresetn),
      .s_axi_awaddr               (s_axi_awaddr),
      .s_axi_awprot               (s_axi_awprot),
      .s_axi_awvalid              (s_axi_awvalid),
      .s_axi_awready              (s_axi_awready),
      .s_axi_wdata                (s_axi_wdata),
      .s_axi_wstrb                (s_axi_wstrb),
      .s_axi_wvalid               (s_axi_wvalid),
      .s_axi_wready               (s_axi_wready),
      .s_axi_bresp                (s_axi_bresp),
      .s_axi_bvalid               (s_axi_bvalid),
      .s_axi_bready               (s_axi_bready),
      .s_axi_araddr               (s_axi_araddr),
      .s_axi_arprot               (s_axi_arprot),
      .s_axi_arvalid              (s_axi_arvalid),
      .s_axi_arready              (s_axi_arready),
      .s_axi_rdata                (s_axi_rdata),
      .s_axi_rresp                (s_axi_rresp),
      .s_axi_rvalid               (s_axi_rvalid),
      .s_axi_rready               (s_axi_rready),
      .external_suspend_ram_input (external_suspend_ram_input),
      .external_soft_off_input    (external_soft_off_input),
      .alarm_event                (alarm_event),
      .sleep_button_event         (sleep_button_event),
      .power_button_event         (power_button_event),
      .wake_event                 (wake_event),
      .power_button_input         (power_button_input),
      .crowbar_condition          (crowbar_condition),
      .unlock_request             (unlock_request),
      .power_button_output        (power_button_output),
      .main_supply_on             (main_supply_on),
      .suspend_ram_group          (suspend_ram_group),
      .soft_off_group             (soft_off_group)
   );
   ssc_acpi_model i_acpi (.aclk(aclk), .aresetn(aresetn), .state_req(ext_req), .slow(ext_slow),
      .suspend_out(external_suspend_ram_input), .soft_off_out(external_soft_off_input));

   task automatic chk_data(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : chk_data
   task automatic chk_resp(input string what, input logic [1:0] exp, input logic [1:0] got);
      chk_data(what, {30'h0, exp}, {30'h0, got});
   endtask : chk_resp
   task automatic chk_cnt(input string what, input int exp, input int got);
      chk_data(what, 32'(exp), 32'(got));
   endtask : chk_cnt

   task automatic wr(input logic [9:0] a, input logic [7:0] d, input logic [1:0] er = 2'h0);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      // No cycle count assumed: only the watchdog ends a stuck wait
      do
      begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready)
            s_axi_awvalid <= 1'h0;
         if (s_axi_wvalid && s_axi_wready)
            s_axi_wvalid <= 1'h0;
      end
      while (!s_axi_bvalid);
      s_axi_bready <= 1'h0;
      chk_resp("bresp", er, s_axi_bresp);
   endtask : wr

   task automatic rd(input logic [9:0] a, input logic [7:0] ed, input logic [1:0] er = 2'h0);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do
      begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready)
            s_axi_arvalid <= 1'h0;
      end
      while (!s_axi_rvalid);
      s_axi_rready <= 1'h0;
      chk_resp("rresp", er, s_axi_rresp);
      chk_data("rdata", {24'h0, ed}, s_axi_rdata);
   endtask : rd

   // Fire one pulse source for a cycle and count output cycles
   task automatic fire(input int k, input int exp);
      int c = 0;
      @(posedge aclk);
      trig[k] <= 1'h1;
      @(posedge aclk);
      trig[k] <= 1'h0;
      repeat (10)
      begin
         @(posedge aclk);
         // Unknown counts as high so that a floating output cannot pass
         if (power_button_output !== 1'h0)
            c++;
      end
      chk_cnt("pulse cycles", exp, c);
   endtask : fire

   task automatic end_sim();
      $display("Checks %0d, mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : end_sim

   initial
   begin
      repeat (12) @(posedge aclk);
      aresetn <= 1'h1;
      rd(A_ACPI, 8'h00);
      rd(A_SLP, 8'h00);
      rd(A_ST, 8'h04);
      wr(A_ACPI, 8'hFF);
      rd(A_ACPI, 8'h87);
      s_axi_wstrb <= 4'h0;
      wr(A_ACPI, 8'h00);
      s_axi_wstrb <= 4'h1;
      rd(A_ACPI, 8'h87);
      wr(A_SLP, 8'h7F);
      rd(A_SLP, 8'h07);
      for (int i = 0; i < 9; i++)
      begin
         wr(A_SLP, t_cfg[i]);
         wr(A_CNT, {3'h0, t_typ[i], 2'h0});
         ext_req <= t_ext[i];
         ext_slow <= ~ext_slow;
         repeat (6) @(posedge aclk);
         rd(A_ST, t_st[i]);
         chk_data("outputs", {24'h0, t_st[i]}, {29'h0, main_supply_on, soft_off_group,
            suspend_ram_group});
      end
      wr(A_SLP, 8'h84);
      wr(A_SLP, 8'h03);
      rd(A_SLP, 8'h84);
      unlock_request <= 1'h1;
      @(posedge aclk);
      unlock_request <= 1'h0;
      rd(A_SLP, 8'h04);
      wr(10'h3FC, 8'h55, SSC_RESP_SLVERR);
      rd(10'h3FC, 8'h00, SSC_RESP_SLVERR);
      for (int i = 0; i < 3; i++)
      begin
         wr(A_ACPI, 8'h01 << i);
         wr(A_EN, 8'h07);
         evt <= 3'h7;
         @(posedge aclk);
         evt <= 3'h0;
         @(posedge aclk);
         chk_data("pulse on enabled event", 32'h1, {31'h0, power_button_output});
         rd(A_STS, 8'h01 << i);
         rd(A_EN, 8'h01 << i);
         wr(A_STS, 8'h07);
         rd(A_STS, 8'h00);
      end
      wr(A_ACPI, 8'h00);
      fire(0, SSC_PULSE_CYCLES);
      wr(A_ACPI, 8'h80);
      fire(0, 0);
      fire(1, SSC_PULSE_CYCLES);
      fire(2, SSC_PULSE_CYCLES);
      wr(A_SLP, 8'h80);
      aresetn <= 1'h0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'h1;
      rd(A_ACPI, 8'h00);
      rd(A_SLP, 8'h00);
      end_sim();
   end

   initial
   begin
      repeat (20000) @(posedge aclk);
      n_fail++;
      end_sim();
   end
endmodule : test_sleep_state_acpi_event_config
